// File: design/mlrsi_pkg.sv
package mlrsi_pkg;
  localparam int NIB_W              = 4;
  localparam int DOTS_PER_ROW       = 320;
  localparam int ROWS_PER_FRAME     = 240;
  localparam int NIBBLES_PER_ROW    = DOTS_PER_ROW / NIB_W;
  localparam int DRIVER_BITS        = 80;
  localparam int NIBBLES_PER_DRIVER = DRIVER_BITS / NIB_W;
  localparam int NUM_DRIVERS        = DOTS_PER_ROW / DRIVER_BITS;
  localparam int ROW_W              = 8;
  localparam int COL_W              = 7;
  localparam int DRV_W              = 3;
  localparam int DCNT_W             = 5;
  localparam int PH_W               = 8;
  localparam int RCNT_W             = 16;

  localparam int CLK_PERIOD_NS      = 50;
  localparam int CLK_HZ             = 20000000;
  localparam int FRAME_HZ_MIN       = 70;
  localparam int FRAME_HZ_MAX       = 80;
  localparam int FRAME_HZ_TARGET    = 75;
  localparam int ROW_CYCLES_DEF     = CLK_HZ / (FRAME_HZ_TARGET * ROWS_PER_FRAME);
  localparam int ROW_CYCLES_MIN     =
    (CLK_HZ + FRAME_HZ_MAX * ROWS_PER_FRAME - 1) / (FRAME_HZ_MAX * ROWS_PER_FRAME);
  localparam int ROW_CYCLES_MAX     = CLK_HZ / (FRAME_HZ_MIN * ROWS_PER_FRAME);

  localparam int T_CP2_NS           = 130;
  localparam int T_CWH_NS           = 60;
  localparam int T_CWL_NS           = 60;
  localparam int T_LWH_NS           = 60;
  localparam int T_SSH_NS           = 60;
  localparam int T_CP2_CYC          = (T_CP2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CWH_CYC          = (T_CWH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CWL_CYC          = (T_CWL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_LWH_CYC          = (T_LWH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_SSH_CYC          = (T_SSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHIFT_HALF_CYCLES  = (T_CWH_CYC > T_CWL_CYC) ? T_CWH_CYC : T_CWL_CYC;

  localparam logic [ROW_W-1:0] SCAN_ROW_RST = ROW_W'(ROWS_PER_FRAME - 1);

  typedef enum logic [3:0] {
    ST_GAP   = 4'h1,
    ST_HI    = 4'h2,
    ST_LO    = 4'h4,
    ST_LATCH = 4'h8
  } mlrsi_host_state_t;
endpackage : mlrsi_pkg

// File: design/mlrsi_link_if.sv
interface mlrsi_link_if;
  import mlrsi_pkg::*;
  logic             nibble_shift_clock;
  logic             row_latch_strobe;
  logic             scan_start_pulse;
  logic [NIB_W-1:0] pixel_nibble_bus;

  modport host (
    output nibble_shift_clock,
    output row_latch_strobe,
    output scan_start_pulse,
    output pixel_nibble_bus
  );

  modport panel (
    input nibble_shift_clock,
    input row_latch_strobe,
    input scan_start_pulse,
    input pixel_nibble_bus
  );
endinterface : mlrsi_link_if

// File: design/mlrsi_col_driver.sv
module mlrsi_col_driver
  import mlrsi_pkg::*;
#(
  parameter int BITS  = DRIVER_BITS,
  parameter int LANES = NIB_W
)(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_select,
  input  wire logic             i_shift,
  input  wire logic [LANES-1:0] i_nibble,
  input  wire logic             i_latch,
  output logic      [BITS-1:0]  o_columns
);
  localparam int DEPTH = BITS / LANES;

  // the shift slice needs at least two nibbles of depth
  if (BITS % LANES != 0 || BITS <= LANES || LANES < 1)
  begin : g_chk
    $error("driver width must be a multiple of the lane count and exceed it");
  end

  logic [BITS-1:0] shreg;
  logic [BITS-1:0] next_shreg;
  logic [BITS-1:0] mapped;
  logic [BITS-1:0] next_columns;

  // lane k of nibble n sits at shreg[(DEPTH-1-n)*LANES+k] once all nibbles are in
  for (genvar d = 0; d < BITS; d++)
  begin : g_map
    assign mapped[d] = shreg[(DEPTH - 1 - d / LANES) * LANES + d % LANES];
  end

  always_comb
  begin
    next_shreg   = shreg;
    next_columns = o_columns;
    // unselected drivers keep their shift lanes frozen
    if (i_shift && i_select)
    begin
      next_shreg = {shreg[BITS-LANES-1:0], i_nibble};
    end
    if (i_latch)
    begin
      next_columns = mapped;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      shreg     <= '0;
      o_columns <= '0;
    end
    else
    begin
      shreg     <= next_shreg;
      o_columns <= next_columns;
    end
  end
endmodule : mlrsi_col_driver

// File: design/mlrsi_panel.sv
module mlrsi_panel
  import mlrsi_pkg::*;
#(
  parameter int POL_ROWS = ROWS_PER_FRAME
)(
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  mlrsi_link_if.panel                  lnk,
  output logic      [DOTS_PER_ROW-1:0] o_row_pixels,
  output logic      [ROW_W-1:0]        o_scan_row,
  output logic                         o_polarity,
  output logic                         o_row_latched
);
  if (POL_ROWS < 1 || POL_ROWS > 256)
  begin : g_chk
    $error("POL_ROWS must lie in 1..256");
  end

  logic [6:0]        sync1;
  logic [6:0]        sync2;
  logic [1:0]        prev;
  logic [6:0]        next_sync1;
  logic [6:0]        next_sync2;
  logic [1:0]        next_prev;
  logic              shift_fall;
  logic              latch_fall;
  logic [DRV_W-1:0]  drv_idx;
  logic [DCNT_W-1:0] drv_cnt;
  logic [ROW_W-1:0]  lat_cnt;
  logic [DRV_W-1:0]  next_drv_idx;
  logic [DCNT_W-1:0] next_drv_cnt;
  logic [ROW_W-1:0]  next_lat_cnt;
  logic [ROW_W-1:0]  next_scan_row;
  logic              next_polarity;
  logic              next_row_latched;

  // both edges are found from the second flop, so data and strobes stay aligned
  always_comb
  begin
    next_sync1 = {lnk.scan_start_pulse, lnk.row_latch_strobe,
                  lnk.nibble_shift_clock, lnk.pixel_nibble_bus};
    next_sync2 = sync1;
    next_prev  = sync2[5:4];
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev  <= next_prev;
    end
  end

  assign shift_fall = prev[0] & ~sync2[4];
  assign latch_fall = prev[1] & ~sync2[5];

  always_comb
  begin
    next_drv_idx     = drv_idx;
    next_drv_cnt     = drv_cnt;
    next_lat_cnt     = lat_cnt;
    next_scan_row    = o_scan_row;
    next_polarity    = o_polarity;
    next_row_latched = 1'h0;
    // extra shift clocks past the last driver are dropped, none is selected
    if (shift_fall && drv_idx < DRV_W'(NUM_DRIVERS))
    begin
      if (drv_cnt == DCNT_W'(NIBBLES_PER_DRIVER - 1))
      begin
        next_drv_cnt = '0;
        next_drv_idx = drv_idx + DRV_W'(1);
      end
      else
      begin
        next_drv_cnt = drv_cnt + DCNT_W'(1);
      end
    end
    if (latch_fall)
    begin
      next_drv_idx     = '0;
      next_drv_cnt     = '0;
      next_row_latched = 1'h1;
      if (sync2[6])
      begin
        next_scan_row = '0;
      end
      else if (o_scan_row == ROW_W'(ROWS_PER_FRAME - 1))
      begin
        next_scan_row = '0;
      end
      else
      begin
        next_scan_row = o_scan_row + ROW_W'(1);
      end
      // free-running count of strobes, not tied to the scan start
      if (lat_cnt == ROW_W'(POL_ROWS - 1))
      begin
        next_lat_cnt  = '0;
        next_polarity = ~o_polarity;
      end
      else
      begin
        next_lat_cnt = lat_cnt + ROW_W'(1);
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      drv_idx       <= '0;
      drv_cnt       <= '0;
      lat_cnt       <= '0;
      o_scan_row    <= SCAN_ROW_RST;
      o_polarity    <= 1'h0;
      o_row_latched <= 1'h0;
    end
    else
    begin
      drv_idx       <= next_drv_idx;
      drv_cnt       <= next_drv_cnt;
      lat_cnt       <= next_lat_cnt;
      o_scan_row    <= next_scan_row;
      o_polarity    <= next_polarity;
      o_row_latched <= next_row_latched;
    end
  end

  // a high bit drives its dot on (white)
  for (genvar i = 0; i < NUM_DRIVERS; i++)
  begin : g_drv
    mlrsi_col_driver #(
      .BITS  (DRIVER_BITS),
      .LANES (NIB_W)
    ) u_drv (
      .i_clock   (i_clock),
      .i_rst     (i_rst),
      .i_select  (drv_idx == DRV_W'(i)),
      .i_shift   (shift_fall),
      .i_nibble  (sync2[3:0]),
      .i_latch   (latch_fall),
      .o_columns (o_row_pixels[i*DRIVER_BITS +: DRIVER_BITS])
    );
  end
endmodule : mlrsi_panel

// File: design/mlrsi_host.sv
// Functional notes
// - pixels travel as 4-bit nibbles, leftmost first
// - panel captures nibbles on falling shift clock
// - host sends 320-dot rows before each latch
// - falling latch strobe moves row to columns
// - scan start high marks first frame row
// - next row shifts in; latch advances row
// - 240 rows per frame, then restart
// - frame rate kept between 70 and 80; ROW_CYCLES is not checked against it
// - panel toggles polarity by counting latch strobes
// - each driver holds 80 bits, four lanes
// - drivers selected left to right, 20 clocks
// - only selected driver accepts bus data
// - host refreshes continuously even for static images
module mlrsi_host
  import mlrsi_pkg::*;
#(
  parameter int ROW_CYCLES = ROW_CYCLES_DEF,
  parameter int SHIFT_HALF = SHIFT_HALF_CYCLES
)(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [NIB_W-1:0] i_fetch_nibble,
  output logic                  o_fetch,
  output logic      [ROW_W-1:0] o_fetch_row,
  output logic      [COL_W-1:0] o_fetch_col,
  output logic                  o_frame_start,
  mlrsi_link_if.host            lnk
);
  localparam int ROW_WORK = NIBBLES_PER_ROW * 2 * SHIFT_HALF + T_LWH_CYC + T_SSH_CYC + 1;

  if (SHIFT_HALF < T_CWH_CYC || SHIFT_HALF < T_CWL_CYC || 2 * SHIFT_HALF < T_CP2_CYC
      || SHIFT_HALF > 255)
  begin : g_chk_half
    $error("SHIFT_HALF violates the shift clock widths");
  end

  if (ROW_CYCLES < ROW_WORK || ROW_CYCLES >= 65536)
  begin : g_chk_row
    $error("ROW_CYCLES too short for one row or too wide for the counter");
  end

  mlrsi_host_state_t state;
  mlrsi_host_state_t next_state;
  logic [PH_W-1:0]   ph;
  logic [PH_W-1:0]   next_ph;
  logic [RCNT_W-1:0] row_cnt;
  logic [RCNT_W-1:0] next_row_cnt;
  logic [ROW_W-1:0]  next_row;
  logic [COL_W-1:0]  next_col;
  logic              clk_q;
  logic              lat_q;
  logic              scan_q;
  logic [NIB_W-1:0]  bus_q;
  logic              next_clk;
  logic              next_lat;
  logic              next_scan;
  logic [NIB_W-1:0]  next_bus;
  logic              row_wrap;
  logic              half_done;
  logic              load_nib;

  // the row timer runs on its own so row pitch never depends on the shift phase
  assign row_wrap  = (row_cnt == RCNT_W'(ROW_CYCLES - 1));
  assign half_done = (ph == PH_W'(SHIFT_HALF - 1));
  assign load_nib  = ((state == ST_GAP) && row_wrap)
                  || ((state == ST_LO) && half_done
                      && (o_fetch_col != COL_W'(NIBBLES_PER_ROW)));

  assign o_fetch       = load_nib;
  assign o_frame_start = (state == ST_LATCH) && (o_fetch_row == '0)
                      && (ph == PH_W'(T_LWH_CYC - 1));

  always_comb
  begin
    next_state   = state;
    next_ph      = ph;
    next_row_cnt = row_wrap ? '0 : row_cnt + RCNT_W'(1);
    next_row     = o_fetch_row;
    next_col     = o_fetch_col;
    next_clk     = clk_q;
    next_lat     = lat_q;
    next_scan    = scan_q;
    next_bus     = bus_q;
    case (state)
      ST_GAP:
      begin
        if (ph != '1)
        begin
          next_ph = ph + PH_W'(1);
        end
        // hold the scan start past the latch fall for its hold time
        if (ph == PH_W'(T_SSH_CYC - 1))
        begin
          next_scan = 1'h0;
        end
        if (row_wrap)
        begin
          next_state = ST_HI;
          next_ph    = '0;
          next_clk   = 1'h1;
          next_scan  = 1'h0;
          next_bus   = i_fetch_nibble;
        end
      end
      ST_HI:
      begin
        next_ph = ph + PH_W'(1);
        if (half_done)
        begin
          next_state = ST_LO;
          next_ph    = '0;
          next_clk   = 1'h0;
          next_col   = o_fetch_col + COL_W'(1);
        end
      end
      ST_LO:
      begin
        next_ph = ph + PH_W'(1);
        if (half_done)
        begin
          next_ph = '0;
          if (o_fetch_col == COL_W'(NIBBLES_PER_ROW))
          begin
            // shift clock stays low for the whole strobe
            next_state = ST_LATCH;
            next_lat   = 1'h1;
            next_scan  = (o_fetch_row == '0);
          end
          else
          begin
            next_state = ST_HI;
            next_clk   = 1'h1;
            next_bus   = i_fetch_nibble;
          end
        end
      end
      ST_LATCH:
      begin
        next_ph = ph + PH_W'(1);
        if (ph == PH_W'(T_LWH_CYC - 1))
        begin
          next_state = ST_GAP;
          next_ph    = '0;
          next_lat   = 1'h0;
          next_col   = '0;
          if (o_fetch_row == ROW_W'(ROWS_PER_FRAME - 1))
          begin
            next_row = '0;
          end
          else
          begin
            next_row = o_fetch_row + ROW_W'(1);
          end
        end
      end
      default:
      begin
        next_state = ST_GAP;
        next_ph    = '0;
        next_clk   = 1'h0;
        next_lat   = 1'h0;
        next_scan  = 1'h0;
        next_col   = '0;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state       <= ST_GAP;
      ph          <= '0;
      row_cnt     <= '0;
      o_fetch_row <= '0;
      o_fetch_col <= '0;
      clk_q       <= 1'h0;
      lat_q       <= 1'h0;
      scan_q      <= 1'h0;
      bus_q       <= '0;
    end
    else
    begin
      state       <= next_state;
      ph          <= next_ph;
      row_cnt     <= next_row_cnt;
      o_fetch_row <= next_row;
      o_fetch_col <= next_col;
      clk_q       <= next_clk;
      lat_q       <= next_lat;
      scan_q      <= next_scan;
      bus_q       <= next_bus;
    end
  end

  // data is passed unchanged: a high bit lights its dot
  assign lnk.nibble_shift_clock = clk_q;
  assign lnk.row_latch_strobe   = lat_q;
  assign lnk.scan_start_pulse   = scan_q;
  assign lnk.pixel_nibble_bus   = bus_q;
endmodule : mlrsi_host

// File: dv/mlrsi_assertions.sv
module mlrsi_link_checker
  import mlrsi_pkg::*;
(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             nibble_shift_clock,
  input  wire logic             row_latch_strobe,
  input  wire logic             scan_start_pulse,
  input  wire logic [NIB_W-1:0] pixel_nibble_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] shifts;
  logic [6:0] next_shifts;
  logic [7:0] rows;
  logic [7:0] next_rows;
  logic       seen;
  logic       next_seen;
  logic       prev_clk;
  logic       prev_lat;
  logic       prev_scan;

  // edges seen on the wire itself, so a stuck design flop cannot hide a miscount
  always_comb
  begin
    next_shifts = shifts;
    next_rows = rows;
    next_seen = seen;
    if (nibble_shift_clock && !prev_clk) next_shifts = shifts + 7'h01;
    if (!row_latch_strobe && prev_lat) next_shifts = 7'h00;
    if (row_latch_strobe && !prev_lat) next_rows = rows + 8'h01;
    if (scan_start_pulse && !prev_scan)
    begin
      next_rows = 8'h01;
      next_seen = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      shifts <= 7'h00;
      rows <= 8'h00;
      seen <= 1'b0;
      prev_clk <= 1'b0;
      prev_lat <= 1'b0;
      prev_scan <= 1'b0;
    end
    else
    begin
      shifts <= next_shifts;
      rows <= next_rows;
      seen <= next_seen;
      prev_clk <= nibble_shift_clock;
      prev_lat <= row_latch_strobe;
      prev_scan <= scan_start_pulse;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  property p_no_shift_in_latch;
    row_latch_strobe |-> !nibble_shift_clock;
  endproperty
  a_no_shift_in_latch: assert property (p_no_shift_in_latch)
    else $error("shift clock high during latch");
  property p_shift_high;
    $rose(nibble_shift_clock) |-> nibble_shift_clock[*2] ##1 !nibble_shift_clock;
  endproperty
  a_shift_high: assert property (p_shift_high)
    else $error("shift clock high phase wrong");
  property p_shift_low;
    $fell(nibble_shift_clock) |-> !nibble_shift_clock[*2];
  endproperty
  a_shift_low: assert property (p_shift_low)
    else $error("shift clock low phase short");
  property p_bus_hold;
    (nibble_shift_clock && !$rose(nibble_shift_clock)) || $fell(nibble_shift_clock)
      |-> $stable(pixel_nibble_bus);
  endproperty
  a_bus_hold: assert property (p_bus_hold)
    else $error("nibble changed around falling shift clock");
  property p_latch_wide;
    $rose(row_latch_strobe) |-> row_latch_strobe[*2] ##1 !row_latch_strobe;
  endproperty
  a_latch_wide: assert property (p_latch_wide)
    else $error("latch strobe width wrong");
  property p_shift_count;
    $rose(row_latch_strobe) |-> shifts == 7'h50;
  endproperty
  a_shift_count: assert property (p_shift_count)
    else $error("shift count per row not 80");
  property p_latch_follows;
    $fell(nibble_shift_clock) && shifts == 7'h50 |-> ##[1:3] $rose(row_latch_strobe);
  endproperty
  a_latch_follows: assert property (p_latch_follows)
    else $error("latch late after last nibble");
  property p_scan_rise;
    $rose(scan_start_pulse) |-> $rose(row_latch_strobe);
  endproperty
  a_scan_rise: assert property (p_scan_rise)
    else $error("scan start not aligned to latch");
  property p_scan_drop;
    $fell(row_latch_strobe) |-> ##[1:3] !scan_start_pulse;
  endproperty
  a_scan_drop: assert property (p_scan_drop)
    else $error("scan start held too long");
  property p_frame_rows;
    $rose(scan_start_pulse) && seen |-> rows == 8'hF0;
  endproperty
  a_frame_rows: assert property (p_frame_rows)
    else $error("frame length not 240 rows");
endmodule : mlrsi_link_checker

// File: dv/tb_top.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t got %0h exp %0h", $time, g, e); end end

module tb_top
  import mlrsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // row pitch just above the 325-cycle minimum keeps a full frame plus wrap inside the run
  localparam int RC    = 330;
  localparam int NROWS = 242;
  localparam int POL   = 4;
  logic                    i_clock = 1'b0;
  logic                    i_rst = 1'b1;
  logic [NIB_W-1:0]        fetch_nib = 4'h0;
  logic [ROW_W-1:0]        frow;
  logic [COL_W-1:0]        fcol;
  logic                    fstart;
  logic [DOTS_PER_ROW-1:0] pix;
  logic [DOTS_PER_ROW-1:0] fpix;
  logic [ROW_W-1:0]        srow;
  logic [ROW_W-1:0]        fsrow;
  logic                    pol;
  logic                    latched;
  logic                    fetch;
  int                      errors = 0;
  int                      check_count = 0;
  int                      nlat = 0;
  int                      nfetch = 0;
  int                      nfs = 0;
  int                      cyc = 0;

  always #25 i_clock = ~i_clock;

  mlrsi_link_if lnk();
  mlrsi_link_if lnk_f();

  mlrsi_host #(.ROW_CYCLES(RC)) i_mlrsi_host (.i_clock(i_clock), .i_rst(i_rst),
    .i_fetch_nibble(fetch_nib), .o_fetch(fetch), .o_fetch_row(frow), .o_fetch_col(fcol),
    .o_frame_start(fstart), .lnk(lnk));
  mlrsi_panel #(.POL_ROWS(POL)) i_mlrsi_panel (.i_clock(i_clock), .i_rst(i_rst), .lnk(lnk),
    .o_row_pixels(pix), .o_scan_row(srow), .o_polarity(pol), .o_row_latched(latched));
  // second panel fed by a hand driver that overruns the row on purpose
  mlrsi_panel i_mlrsi_panel_flt (.i_clock(i_clock), .i_rst(i_rst), .lnk(lnk_f),
    .o_row_pixels(fpix), .o_scan_row(fsrow), .o_polarity(), .o_row_latched());
  mlrsi_link_checker i_mlrsi_link_checker (.i_clock(i_clock), .i_rst(i_rst),
    .nibble_shift_clock(lnk.nibble_shift_clock), .row_latch_strobe(lnk.row_latch_strobe),
    .scan_start_pulse(lnk.scan_start_pulse), .pixel_nibble_bus(lnk.pixel_nibble_bus));

  function automatic logic [NIB_W-1:0] pat(input int r, input int c);
    return NIB_W'(r * 7 + c * 3 + 5);
  endfunction : pat

  function automatic logic [DOTS_PER_ROW-1:0] exp_row(input int r);
    logic [DOTS_PER_ROW-1:0] v;
    for (int n = 0; n < NIBBLES_PER_ROW; n++) v[4*n +: 4] = pat(r, n);
    return v;
  endfunction : exp_row

  task automatic final_report;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic f_nib(input logic [NIB_W-1:0] v);
    @(negedge i_clock);
    lnk_f.pixel_nibble_bus = v;
    repeat (2) @(negedge i_clock);
    lnk_f.nibble_shift_clock = 1'b1;
    repeat (2) @(negedge i_clock);
    lnk_f.nibble_shift_clock = 1'b0;
  endtask : f_nib

  task automatic f_row(input int r, input int extra, input logic scan);
    for (int n = 0; n < NIBBLES_PER_ROW + extra; n++)
      f_nib(n < NIBBLES_PER_ROW ? pat(r, n) : 4'hF);
    repeat (2) @(negedge i_clock);
    lnk_f.row_latch_strobe = 1'b1;
    lnk_f.scan_start_pulse = scan;
    repeat (2) @(negedge i_clock);
    lnk_f.row_latch_strobe = 1'b0;
    repeat (4) @(negedge i_clock);
    lnk_f.scan_start_pulse = 1'b0;
  endtask : f_row

  // address stands two cycles before each fetch, so a falling-edge update is safe
  always @(negedge i_clock) fetch_nib <= pat(frow, fcol);

  // row pitch and fetch count are measured per latched row
  always @(negedge i_clock)
  begin
    cyc++;
    if (fetch === 1'b1) nfetch++;
    if (fstart === 1'b1) nfs++;
    if (latched === 1'b1)
    begin
      `CHK(pix, exp_row(nlat % ROWS_PER_FRAME))
      `CHK(srow, ROW_W'(nlat % ROWS_PER_FRAME))
      `CHK(pol, 1'(((nlat + 1) / POL) % 2))
      `CHK(nfetch, NIBBLES_PER_ROW)
      if (nlat > 0) `CHK(cyc, RC)
      nlat++;
      nfetch = 0;
      cyc = 0;
    end
    if (fstart === 1'b1) `CHK(lnk.scan_start_pulse, 1'b1)
  end

  initial
  begin
    lnk_f.nibble_shift_clock = 1'b0;
    lnk_f.row_latch_strobe = 1'b0;
    lnk_f.scan_start_pulse = 1'b0;
    lnk_f.pixel_nibble_bus = 4'h0;
    repeat (20) @(negedge i_clock);
    i_rst = 1'b0;
    f_row(3, 4, 1'b1);
    `CHK(fpix, exp_row(3))
    `CHK(fsrow, 8'h00)
    f_row(9, 0, 1'b0);
    `CHK(fpix, exp_row(9))
    `CHK(fsrow, 8'h01)
    for (int i = 0; i < (NROWS + 2) * RC && nlat < NROWS; i++) @(negedge i_clock);
    `CHK(nlat, NROWS)
    `CHK(nfs, (NROWS + ROWS_PER_FRAME - 1) / ROWS_PER_FRAME)
    final_report;
  end

  initial
  begin
    #((NROWS + 20) * RC * 50);
    errors++;
    final_report;
  end
endmodule : tb_top
